//--- hdl/status_word_pkg.sv
package status_word_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PE_WORDS = 24;
  localparam int NUM_GROUPS = 24;
  localparam int GROUP_POINTS = 16;
  localparam int SET_POINTS = 4;
  localparam int NUM_EXT_LEVELS = 24;
  localparam int NUM_DEVICES = 4;
  localparam int DEV_WORDS = 2;
  localparam int NUM_TIMERS = 3;
  localparam int NUM_INT_ERRORS = 4;

  // Bit 0 is the most significant accumulator position
  typedef logic [0:15] status_word_t;

  typedef struct packed {
    logic [4:0] area;
    logic [2:0] func;
    logic [7:0] modifier;
  } io_command_word_t;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_CORE_ADDRESS = 8'h04;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'h08;
  localparam logic [7:0] ADDR_LEVEL_REQ = 8'h0C;
  localparam logic [15:0] RESET_CORE_ADDRESS = 16'h0000;
  localparam logic [15:0] RESET_ACCUMULATOR = 16'h0000;

  // ----------------------------------------------------------------
  // Command encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] FUNC_READ = 3'h2;
  localparam logic [2:0] FUNC_SENSE_LEVEL = 3'h3;
  localparam logic [2:0] FUNC_SENSE_DEVICE = 3'h7;
  localparam int MOD_RESET_BIT = 0;
  localparam int MOD_WORD_BIT = 1;
  localparam logic [7:0] PE_FIRST_MOD = 8'h02;
  localparam logic [7:0] PE_LAST_MOD = 8'h19;

  // ----------------------------------------------------------------
  // Area codes
  // ----------------------------------------------------------------
  localparam logic [4:0] AREA_PROCESS_EVENT = 5'h0A;
  localparam logic [4:0] AREA_TIMER = 5'h01;
  localparam logic [4:0] AREA_TYPEWRITER = 5'h02;
  localparam logic [4:0] AREA_CONSOLE = 5'h03;
  localparam logic [4:0] AREA_AUX_DEVICE = 5'h04;
  localparam logic [4:0] DEV_AREA [NUM_DEVICES] = '{AREA_TIMER, AREA_TYPEWRITER, AREA_CONSOLE, AREA_AUX_DEVICE};

  // ----------------------------------------------------------------
  // Level status bit assignment
  // ----------------------------------------------------------------
  // Process-event word i sits on level i, bit 0; devices take bit 1
  localparam logic [3:0] PE_LEVEL_BIT = 4'h0;
  localparam logic [4:0] DEV_LEVEL [NUM_DEVICES] = '{5'h00, 5'h01, 5'h02, 5'h03};
  localparam logic [3:0] DEV_LEVEL_BIT [NUM_DEVICES] = '{4'h1, 4'h1, 4'h1, 4'h1};

  // Device word bits 0-7 are resettable interrupt indicators
  localparam status_word_t DEV_RESETTABLE = 16'hFF00;
  localparam status_word_t DEV_INTERRUPT = 16'hFF00;

endpackage : status_word_pkg

//--- hdl/status_word_interrupt_aggregator.sv
// Operation
// - Sense-device command copies the addressed device status word into the accumulator.
// - Area and modifier fields pick the device and which of its words.
// - Modifier bit 15 set on sense-device clears resettable indicators of that word.
// - Non-resettable indicators follow only the device's own condition.
// - Process-event latch sets on contact closure or voltage shift, holds until read.
// - Read command stores the word to core; sense-device puts it in accumulator.
// - Any read or sense of a process-event word clears all its latches.
// - Each adapter serves three sixteen-input groups, split into four-input sets.
// - Input position n drives bit n of its process-event word.
// - Process-event words 1 to 24 answer modifier addresses 2 to 25.
// - Each level except trace and maintenance has a 16-bit level status word.
// - Level status bit is OR of its word's latches or device indicators.
// - Any set level status bit raises that level's service request.
// - Sense-level returns the highest-priority requesting level's status word.
// - Reading a level status word leaves indicators unchanged, internal level excepted.
// - Internal-error level status word clears when sensed.
// - Each status word feeds exactly one level status bit.
// - One level status bit combines requesters of a single area code.
// - One adapter's three words stay within levels 0-11 or 12-23.
// - Level status bits fill from bit 0 upward.
// - Timer, first typewriter and console requests always have level bits.
`timescale 1ns/1ps
`default_nettype none
module status_word_interrupt_aggregator
  import status_word_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Process contact inputs, group g point n at index g*16+n
  input wire logic [NUM_GROUPS*GROUP_POINTS-1:0] process_point_in,
  // Device adapters
  input wire logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] dev_set_in,
  input wire logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] dev_cond_in,
  input wire logic [NUM_TIMERS-1:0] timer_request_in,
  input wire logic console_request_in,
  input wire logic [NUM_INT_ERRORS-1:0] internal_error_in,
  // Core storage write for read commands
  output logic core_wr_out,
  output logic [15:0] core_addr_out,
  output logic [15:0] core_data_out,
  // Service requests, bit 0 internal level, bit k+1 external level k
  output logic [NUM_EXT_LEVELS:0] level_req_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Every set of a group goes to the group's own word; any set mapping
  // keeps the bit position, so only the word index could change here
  function automatic int pe_word_of(input int group, input int set);
    pe_word_of = group;
  endfunction : pe_word_of

  function automatic logic pe_selected(input logic [7:0] modifier);
    pe_selected = (modifier >= PE_FIRST_MOD) && (modifier <= PE_LAST_MOD);
  endfunction : pe_selected

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Process contact synchronisers and edge detect
  // ----------------------------------------------------------------
  localparam int NPTS = NUM_GROUPS * GROUP_POINTS;
  logic [NPTS-1:0] pt_meta;
  logic [NPTS-1:0] pt_sync;
  logic [NPTS-1:0] pt_prev;
  logic [NPTS-1:0] pt_event;

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      pt_meta <= '0;
      pt_sync <= '0;
      pt_prev <= '0;
    end else begin
      pt_meta <= process_point_in;
      pt_sync <= pt_meta;
      pt_prev <= pt_sync;
    end
  end

  // Closure or voltage shift shows as a rising level
  assign pt_event = pt_sync & ~pt_prev;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  io_command_word_t cmd;
  logic cmd_strobe;
  logic is_pe_area;
  logic [4:0] pe_index;
  logic sense_dev;
  logic read_cmd;
  logic sense_lvl;
  logic [15:0] core_address;

  assign cmd = io_command_word_t'(reg_wdata_in[15:0]);
  assign cmd_strobe = reg_wr_in && (reg_addr_in == ADDR_COMMAND);
  assign sense_dev = cmd_strobe && (cmd.func == FUNC_SENSE_DEVICE);
  assign read_cmd = cmd_strobe && (cmd.func == FUNC_READ);
  assign sense_lvl = cmd_strobe && (cmd.func == FUNC_SENSE_LEVEL);
  assign is_pe_area = (cmd.area == AREA_PROCESS_EVENT) && pe_selected(cmd.modifier);
  assign pe_index = 5'(cmd.modifier - PE_FIRST_MOD);

  // ----------------------------------------------------------------
  // Process-event latches
  // ----------------------------------------------------------------
  status_word_t pe_word [NUM_PE_WORDS];
  status_word_t pe_set [NUM_PE_WORDS];
  logic [NUM_PE_WORDS-1:0] pe_clear;

  always_comb begin
    for (int w = 0; w < NUM_PE_WORDS; w++) begin
      pe_set[w] = '0;
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      for (int n = 0; n < GROUP_POINTS; n++) begin
        pe_set[pe_word_of(g, n / SET_POINTS)][n] |= pt_event[g*GROUP_POINTS+n];
      end
    end
  end

  always_comb begin
    pe_clear = '0;
    if ((sense_dev || read_cmd) && is_pe_area) begin
      pe_clear[pe_index] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int w = 0; w < NUM_PE_WORDS; w++) begin
        pe_word[w] <= '0;
      end
    end else begin
      // A closure landing in the clearing cycle is kept
      for (int w = 0; w < NUM_PE_WORDS; w++) begin
        pe_word[w] <= (pe_clear[w] ? '0 : pe_word[w]) | pe_set[w];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device status words
  // ----------------------------------------------------------------
  status_word_t dev_latch [NUM_DEVICES][DEV_WORDS];
  status_word_t dev_word [NUM_DEVICES][DEV_WORDS];
  status_word_t dev_set [NUM_DEVICES][DEV_WORDS];
  logic [NUM_DEVICES-1:0] dev_hit;
  logic dev_word_sel;

  assign dev_word_sel = cmd.modifier[MOD_WORD_BIT];

  always_comb begin
    for (int d = 0; d < NUM_DEVICES; d++) begin
      dev_hit[d] = (cmd.area == DEV_AREA[d]);
      for (int w = 0; w < DEV_WORDS; w++) begin
        dev_set[d][w] = dev_set_in[d][w] & DEV_RESETTABLE;
      end
    end
    // Interval timers and console key land in their device's word 0
    for (int t = 0; t < NUM_TIMERS; t++) begin
      dev_set[0][0][t] |= timer_request_in[t];
    end
    dev_set[2][0][0] |= console_request_in;
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int d = 0; d < NUM_DEVICES; d++) begin
        for (int w = 0; w < DEV_WORDS; w++) begin
          dev_latch[d][w] <= '0;
        end
      end
    end else begin
      for (int d = 0; d < NUM_DEVICES; d++) begin
        for (int w = 0; w < DEV_WORDS; w++) begin
          if (sense_dev && dev_hit[d] && cmd.modifier[MOD_RESET_BIT] && (int'(dev_word_sel) == w)) begin
            dev_latch[d][w] <= dev_set[d][w];
          end else begin
            dev_latch[d][w] <= dev_latch[d][w] | dev_set[d][w];
          end
        end
      end
    end
  end

  // Condition bits follow the device directly and ignore any reset command
  always_comb begin
    for (int d = 0; d < NUM_DEVICES; d++) begin
      for (int w = 0; w < DEV_WORDS; w++) begin
        dev_word[d][w] = dev_latch[d][w] | (dev_cond_in[d][w] & ~DEV_RESETTABLE);
      end
    end
  end

  // ----------------------------------------------------------------
  // Level status words
  // ----------------------------------------------------------------
  status_word_t level_word [NUM_EXT_LEVELS];
  status_word_t internal_word;

  // Fixed assignment: one bit per requester, one area per bit, filled from bit 0;
  // words 0-2 of each adapter land on levels within the same half
  always_comb begin
    for (int l = 0; l < NUM_EXT_LEVELS; l++) begin
      level_word[l] = '0;
    end
    for (int w = 0; w < NUM_PE_WORDS; w++) begin
      level_word[w][PE_LEVEL_BIT] = |pe_word[w];
    end
    for (int d = 0; d < NUM_DEVICES; d++) begin
      level_word[DEV_LEVEL[d]][DEV_LEVEL_BIT[d]] =
        |(dev_word[d][0] & DEV_INTERRUPT) | |(dev_word[d][1] & DEV_INTERRUPT);
    end
  end

  // Internal-error word clears when sensed, an error in that cycle is kept
  logic internal_sensed;

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      internal_word <= '0;
    end else begin
      internal_word[0:NUM_INT_ERRORS-1] <=
        (internal_sensed ? '0 : internal_word[0:NUM_INT_ERRORS-1]) | internal_error_in;
      internal_word[NUM_INT_ERRORS:15] <= '0;
    end
  end

  // Highest priority requester: internal first, then level 0 upward
  status_word_t top_word;
  logic top_is_internal;

  always_comb begin
    top_word = '0;
    top_is_internal = 1'b0;
    if (|internal_word) begin
      top_word = internal_word;
      top_is_internal = 1'b1;
    end else begin
      for (int l = NUM_EXT_LEVELS - 1; l >= 0; l--) begin
        if (|level_word[l]) begin
          top_word = level_word[l];
        end
      end
    end
  end

  // Only the internal word is cleared by a level sense
  assign internal_sensed = sense_lvl && top_is_internal;

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      level_req_out <= '0;
    end else begin
      level_req_out[0] <= |internal_word;
      for (int l = 0; l < NUM_EXT_LEVELS; l++) begin
        level_req_out[l+1] <= |level_word[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Selected word for sense-device into the accumulator
  // ----------------------------------------------------------------
  status_word_t sensed_word;

  always_comb begin
    sensed_word = '0;
    if (is_pe_area) begin
      sensed_word = pe_word[pe_index];
    end
    for (int d = 0; d < NUM_DEVICES; d++) begin
      if (dev_hit[d]) begin
        sensed_word = dev_word[d][dev_word_sel];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and core write
  // ----------------------------------------------------------------
  status_word_t accumulator;
  logic [15:0] last_command;

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      accumulator <= RESET_ACCUMULATOR;
    end else if (sense_dev) begin
      accumulator <= sensed_word;
    end else if (sense_lvl) begin
      accumulator <= top_word;
    end
  end

  // Read command only reaches process-event words; other areas write nothing
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      core_wr_out <= 1'b0;
      core_addr_out <= '0;
      core_data_out <= '0;
    end else begin
      core_wr_out <= read_cmd && is_pe_area;
      if (read_cmd && is_pe_area) begin
        core_addr_out <= core_address;
        core_data_out <= pe_word[pe_index];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      core_address <= RESET_CORE_ADDRESS;
      last_command <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CORE_ADDRESS) begin
        core_address <= reg_wdata_in[15:0];
      end
      if (reg_addr_in == ADDR_COMMAND) begin
        last_command <= reg_wdata_in[15:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_COMMAND: reg_rdata_out <= {16'h0000, last_command};
        ADDR_CORE_ADDRESS: reg_rdata_out <= {16'h0000, core_address};
        ADDR_ACCUMULATOR: reg_rdata_out <= {16'h0000, accumulator};
        ADDR_LEVEL_REQ: reg_rdata_out <= {7'h00, level_req_out};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule : status_word_interrupt_aggregator
`default_nettype wire

//--- verif/aggregator_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module aggregator_asserts
  import status_word_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Requesters
  input wire logic [NUM_GROUPS*GROUP_POINTS-1:0] process_point_in,
  input wire logic [NUM_TIMERS-1:0] timer_request_in,
  input wire logic console_request_in,
  input wire logic [NUM_INT_ERRORS-1:0] internal_error_in,
  // Outputs
  input wire logic core_wr_out,
  input wire logic [15:0] core_addr_out,
  input wire logic [NUM_EXT_LEVELS:0] level_req_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // Shadow of the core address register
  // ----------------------------------------------------------------
  logic [15:0] core_addr;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_addr <= RESET_CORE_ADDRESS;
    end else if (reg_wr_in && reg_addr_in == ADDR_CORE_ADDRESS) begin
      core_addr <= reg_wdata_in[15:0];
    end
  end
  sequence pe_read_s;
    reg_wr_in && reg_addr_in == ADDR_COMMAND && reg_wdata_in[15:11] == AREA_PROCESS_EVENT &&
      reg_wdata_in[10:8] == FUNC_READ && reg_wdata_in[7:0] >= PE_FIRST_MOD && reg_wdata_in[7:0] <= PE_LAST_MOD;
  endsequence
  sequence one_pulse_s;
    core_wr_out ##1 !core_wr_out;
  endsequence
  sequence int_sense_s;
    reg_wr_in && reg_addr_in == ADDR_COMMAND && reg_wdata_in[10:8] == FUNC_SENSE_LEVEL && level_req_out[0] &&
      internal_error_in == '0 ##1 internal_error_in == '0;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  core_pulse_a: assert property (pe_read_s |=> one_pulse_s)
    else $error("core write pulse missing after read command");
  core_cause_a: assert property (core_wr_out |-> $past(reg_wr_in) && $past(reg_wdata_in[10:8]) == FUNC_READ)
    else $error("core write without read command");
  core_addr_a: assert property (core_wr_out |-> core_addr_out == core_addr)
    else $error("core write address differs from register");
  int_req_a: assert property ((|internal_error_in) |-> ##[1:3] level_req_out[0])
    else $error("internal level not requested");
  int_clear_a: assert property (int_sense_s |=> !level_req_out[0])
    else $error("internal level not cleared by sense");
  timer_req_a: assert property ((|timer_request_in) |-> ##[1:3] level_req_out[1])
    else $error("timer request not on level 0");
  console_req_a: assert property (console_request_in |-> ##[1:3] level_req_out[3])
    else $error("console request not on level 2");
  level_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == ADDR_LEVEL_REQ |->
    reg_rdata_out == {7'h00, $past(level_req_out)})
    else $error("level request read mismatch");
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : grp
    pe_req_a: assert property ((|(process_point_in[g*GROUP_POINTS +: GROUP_POINTS] &
      ~$past(process_point_in[g*GROUP_POINTS +: GROUP_POINTS]))) |-> ##[2:8] level_req_out[g+1])
      else $error("process event did not request its level");
  end
endmodule : aggregator_asserts
bind status_word_interrupt_aggregator aggregator_asserts aggregator_asserts_inst (.clk_in(clk_in),
  .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .process_point_in(process_point_in),
  .timer_request_in(timer_request_in), .console_request_in(console_request_in),
  .internal_error_in(internal_error_in), .core_wr_out(core_wr_out), .core_addr_out(core_addr_out),
  .level_req_out(level_req_out));
`default_nettype wire

//--- verif/process_partner.sv
`timescale 1ns/1ps
`default_nettype none
module process_partner
  import status_word_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Contacts and adapters
  output logic [NUM_GROUPS*GROUP_POINTS-1:0] point_out,
  output logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] set_out,
  output logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] cond_out,
  output logic [NUM_TIMERS-1:0] timer_out,
  output logic console_out,
  output logic [NUM_INT_ERRORS-1:0] error_out
);
  initial begin
    point_out = '0;
    set_out = '0;
    cond_out = '0;
    timer_out = '0;
    console_out = 1'b0;
    error_out = '0;
  end
  // Contacts are plain levels; a closure is a rising level
  task automatic contact(input int idx, input logic v);
    @(posedge clk_in);
    point_out[idx] <= v;
  endtask : contact
  task automatic condition(input int d, input int w, input logic [15:0] m);
    @(posedge clk_in);
    cond_out[d][w] <= m;
  endtask : condition
  // Pulses last exactly one cycle, as the adapters give them
  task automatic pulse(input int d, input int w, input logic [15:0] m, input logic [2:0] t,
                       input logic c, input logic [3:0] e);
    @(posedge clk_in);
    set_out[d][w] <= m;
    timer_out <= t;
    console_out <= c;
    error_out <= e;
    @(posedge clk_in);
    set_out <= '0;
    timer_out <= '0;
    console_out <= 1'b0;
    error_out <= '0;
  endtask : pulse
endmodule : process_partner
`default_nettype wire

//--- verif/status_word_interrupt_aggregator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module status_word_interrupt_aggregator_bench
  import status_word_pkg::*;
;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata;
  logic [NUM_GROUPS*GROUP_POINTS-1:0] points;
  logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] dset;
  logic [NUM_DEVICES-1:0][DEV_WORDS-1:0][15:0] dcond;
  logic [NUM_TIMERS-1:0] timers;
  logic console;
  logic [NUM_INT_ERRORS-1:0] errors;
  logic core_wr;
  logic [15:0] core_addr;
  logic [15:0] core_data;
  logic [NUM_EXT_LEVELS:0] level_req;
  int error_cnt = 0;
  int total_checks = 0;
  status_word_interrupt_aggregator status_word_interrupt_aggregator_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .process_point_in(points), .dev_set_in(dset), .dev_cond_in(dcond),
    .timer_request_in(timers), .console_request_in(console), .internal_error_in(errors),
    .core_wr_out(core_wr), .core_addr_out(core_addr), .core_data_out(core_data), .level_req_out(level_req));
  process_partner process_partner_inst (.clk_in(clk_in), .point_out(points), .set_out(dset),
    .cond_out(dcond), .timer_out(timers), .console_out(console), .error_out(errors));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic cmd(input logic [4:0] ar, input logic [2:0] f, input logic [7:0] m);
    wr(ADDR_COMMAND, {16'h0000, ar, f, m});
  endtask : cmd
  task automatic sense(input logic [4:0] ar, input logic [2:0] f, input logic [7:0] m, output logic [15:0] v);
    logic [31:0] r;
    cmd(ar, f, m);
    rd(ADDR_ACCUMULATOR, r);
    v = r[15:0];
  endtask : sense
  task automatic settle();
    repeat (6) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] r;
    rd(ADDR_LEVEL_REQ, r);
    `CHK(r, 32'h0)
    rd(ADDR_ACCUMULATOR, r);
    `CHK(r, {16'h0000, RESET_ACCUMULATOR})
    rd(ADDR_CORE_ADDRESS, r);
    `CHK(r, {16'h0000, RESET_CORE_ADDRESS})
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, r);
    `CHK(r, 32'h0)
  endtask : t_reset_values
  // Each word in turn: latch holds after the contact opens, sense clears it
  task automatic t_pe_words();
    logic [15:0] v;
    int n;
    for (int g = 0; g < NUM_PE_WORDS; g++) begin
      n = g % GROUP_POINTS;
      process_partner_inst.contact(g*GROUP_POINTS + n, 1'b1);
      settle();
      `CHK(level_req, 25'(1) << (g + 1))
      process_partner_inst.contact(g*GROUP_POINTS + n, 1'b0);
      settle();
      `CHK(level_req[g+1], 1'b1)
      sense(AREA_PROCESS_EVENT, FUNC_SENSE_DEVICE, PE_FIRST_MOD + 8'(g), v);
      `CHK(v, 16'h8000 >> n)
      settle();
      `CHK(level_req, 25'h0)
    end
  endtask : t_pe_words
  task automatic t_pe_read();
    logic [31:0] r;
    wr(ADDR_CORE_ADDRESS, 32'h0000_1234);
    for (int i = 4; i < 8; i++) process_partner_inst.contact(5*GROUP_POINTS + i, 1'b1);
    settle();
    cmd(AREA_PROCESS_EVENT, FUNC_READ, PE_FIRST_MOD + 8'h05);
    #1;
    `CHK(core_wr, 1'b1)
    `CHK(core_addr, 16'h1234)
    `CHK(core_data, 16'h0F00)
    rd(ADDR_ACCUMULATOR, r);
    `CHK(r[15:0], 16'h0100)
    settle();
    `CHK(level_req[6], 1'b0)
    for (int i = 4; i < 8; i++) process_partner_inst.contact(5*GROUP_POINTS + i, 1'b0);
  endtask : t_pe_read
  task automatic t_levels();
    logic [15:0] v;
    process_partner_inst.pulse(0, 0, 16'h0000, 3'b010, 1'b0, 4'h0);
    process_partner_inst.contact(3, 1'b1);
    settle();
    sense(5'h00, FUNC_SENSE_LEVEL, 8'h00, v);
    `CHK(v, 16'hC000)
    process_partner_inst.pulse(0, 0, 16'h0000, 3'b000, 1'b1, 4'b0100);
    settle();
    `CHK(level_req, 25'hB)
    sense(5'h00, FUNC_SENSE_LEVEL, 8'h00, v);
    `CHK(v, 16'h4000)
    settle();
    `CHK(level_req, 25'h8 | 25'h2)
    sense(5'h00, FUNC_SENSE_LEVEL, 8'h00, v);
    `CHK(v, 16'hC000)
    sense(AREA_CONSOLE, FUNC_SENSE_DEVICE, 8'h01, v);
    `CHK(v, 16'h8000)
    sense(AREA_TIMER, FUNC_SENSE_DEVICE, 8'h01, v);
    `CHK(v, 16'h4000)
    sense(AREA_PROCESS_EVENT, FUNC_SENSE_DEVICE, PE_FIRST_MOD, v);
    `CHK(v, 16'h1000)
    settle();
    `CHK(level_req, 25'h0)
    process_partner_inst.contact(3, 1'b0);
  endtask : t_levels
  task automatic t_dev_words();
    logic [15:0] v;
    process_partner_inst.pulse(3, 1, 16'h4000, 3'b000, 1'b0, 4'h0);
    process_partner_inst.condition(3, 1, 16'h0001);
    settle();
    `CHK(level_req, 25'h10)
    sense(AREA_AUX_DEVICE, FUNC_SENSE_DEVICE, 8'h00, v);
    `CHK(v, 16'h0000)
    sense(AREA_AUX_DEVICE, FUNC_SENSE_DEVICE, 8'h02, v);
    `CHK(v, 16'h4001)
    sense(AREA_AUX_DEVICE, FUNC_SENSE_DEVICE, 8'h03, v);
    `CHK(v, 16'h4001)
    sense(AREA_AUX_DEVICE, FUNC_SENSE_DEVICE, 8'h02, v);
    `CHK(v, 16'h0001)
    process_partner_inst.condition(3, 1, 16'h0000);
    settle();
    `CHK(level_req, 25'h0)
    sense(AREA_AUX_DEVICE, FUNC_SENSE_DEVICE, 8'h02, v);
    `CHK(v, 16'h0000)
    process_partner_inst.pulse(1, 0, 16'h8000, 3'b000, 1'b0, 4'h0);
    settle();
    sense(5'h00, FUNC_SENSE_LEVEL, 8'h00, v);
    `CHK(v, 16'h4000)
    sense(AREA_TYPEWRITER, FUNC_SENSE_DEVICE, 8'h01, v);
    sense(5'h00, FUNC_SENSE_LEVEL, 8'h00, v);
    `CHK(v, 16'h0000)
  endtask : t_dev_words
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_reset_values();
    t_pe_words();
    t_pe_read();
    t_levels();
    t_dev_words();
    report_and_stop();
  end
  // Whole run is under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    report_and_stop();
  end
endmodule : status_word_interrupt_aggregator_bench
`default_nettype wire
